// ==== design/sbdp_params.svh ====
`ifndef SBDP_PARAMS_SVH
`define SBDP_PARAMS_SVH
`define SBDP_DATA_W     64
`define SBDP_GRP_W      16
`define SBDP_GRPS       4
`define SBDP_FLIP_LIMIT 5'h08
`define SBDP_NEG_RST    1'b1
`endif

// ==== design/sbdp_pkg.sv ====
package sbdp_pkg;
   typedef struct packed {
      logic [63:0] data;
      logic        last;
   } sbdp_beat_t;

   typedef struct packed {
      logic [63:0] data;
      logic [3:0]  invN;
      logic [3:0]  parN;
   } sbdp_bus_t;

   typedef enum logic [1:0] {
      SBDP_IDLE    = 2'b00,
      SBDP_WAIT    = 2'b01,
      SBDP_DRIVE   = 2'b10,
      SBDP_RELEASE = 2'b11
   } sbdp_state_t;
endpackage

// ==== design/sbdp_data_phase.sv ====
`timescale 1ns/1ps
`include "sbdp_params.svh"
// Overview of operation
// - The driving agent holds bus-busy asserted throughout its data tenure.
// - Start driving only after the other driver has released bus-busy.
// - Four parity signals protect the 64-bit data bus.
// - Whoever drives the data also drives its parity in that transfer.
// - Data-valid is asserted by the driver on every data transfer.
// - Driver may drop data-valid for idle clocks; receivers skip those clocks.
// - Invert a 16-bit group and flag it if over half its bits would toggle.
module sbdp_data_phase
   import sbdp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        busClk,
   input  wire logic [63:0] txWord,
   input  wire logic        txLast,
   input  wire logic        txValid,
   output logic             txReady,
   output logic [63:0]      rxWord,
   output logic             rxValid,
   output logic             rxParityErr,
   output logic             rxOverrun,
   output logic             deferSeen,
   input  wire logic [63:0] dataIn,
   output logic [63:0]      dataOut,
   output logic             dataOe,
   input  wire logic [3:0]  group_inverted_n_in,
   output logic [3:0]       group_inverted_n_out,
   input  wire logic [3:0]  data_parity_n_in,
   output logic [3:0]       data_parity_n_out,
   input  wire logic        data_valid_n_in,
   output logic             data_valid_n_out,
   output logic             data_valid_n_oe,
   input  wire logic        data_bus_in_use_n_in,
   output logic             data_bus_in_use_n_out,
   output logic             data_bus_in_use_n_oe,
   input  wire logic        completion_postponed_n
);

   // ************************************************************
   // Helper functions
   // ************************************************************
   function automatic logic [4:0] flipCount(input logic [15:0] v);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < `SBDP_GRP_W; i++)
      begin
         n = n + {4'h0, v[i]};
      end
      return n;
   endfunction

   // Even parity over a group as it appears on the wires, sent active low
   function automatic logic [3:0] busParityN(input logic [63:0] v);
      logic [3:0] p;
      p = 4'h0;
      for (int g = 0; g < `SBDP_GRPS; g++)
      begin
         p[g] = ~(^v[g*16 +: 16]);
      end
      return p;
   endfunction

   function automatic sbdp_bus_t encode(input logic [63:0] w, input logic [63:0] prev);
      sbdp_bus_t b;
      b.data = w;
      b.invN = 4'hF;
      for (int g = 0; g < `SBDP_GRPS; g++)
      begin
         if (flipCount(w[g*16 +: 16] ^ prev[g*16 +: 16]) > `SBDP_FLIP_LIMIT)
         begin
            b.data[g*16 +: 16] = ~w[g*16 +: 16];
            b.invN[g]          = 1'b0;
         end
      end
      b.parN = busParityN(b.data);
      return b;
   endfunction

   // ************************************************************
   // Link reset and core-to-link transmit handshake
   // ************************************************************
   // Core holds a word and flips a toggle; the link flips its own ack toggle to match when used
   logic [1:0]  lnkRstSync_q;
   logic        lnkRst;
   sbdp_beat_t  txHold_q, txHold_d;
   logic        txReqTgl_q, txReqTgl_d;
   logic [1:0]  txAckSync_q;
   logic        txReady_q, txReady_d;

   always_ff @(posedge busClk)
   begin
      lnkRstSync_q <= {lnkRstSync_q[0], sys_rst};
   end
   assign lnkRst = lnkRstSync_q[1];

   logic txAckTgl_q;

   always_comb
   begin
      txHold_d   = txHold_q;
      txReqTgl_d = txReqTgl_q;
      txReady_d  = txReady_q;
      if (txReady_q && txValid)
      begin
         txHold_d   = '{data: txWord, last: txLast};
         txReqTgl_d = ~txReqTgl_q;
         txReady_d  = 1'b0;
      end
      else if (!txReady_q && (txAckSync_q[1] == txReqTgl_q))
      begin
         txReady_d = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      txAckSync_q <= {txAckSync_q[0], txAckTgl_q};
      if (sys_rst)
      begin
         txHold_q   <= '0;
         txReqTgl_q <= 1'b0;
         txReady_q  <= 1'b0;
      end
      else
      begin
         txHold_q   <= txHold_d;
         txReqTgl_q <= txReqTgl_d;
         txReady_q  <= txReady_d;
      end
   end
   assign txReady = txReady_q;

   // ************************************************************
   // Bus pin synchronisers
   // ************************************************************
   logic [1:0]  reqSync_q;
   sbdp_bus_t   pinS1_q, pinS2_q;
   logic [1:0]  validS_q, busyS_q;
   logic [1:0]  rxAckSync_q;

   always_ff @(posedge busClk)
   begin
      reqSync_q   <= {reqSync_q[0], txReqTgl_q};
      pinS1_q     <= '{data: dataIn, invN: group_inverted_n_in, parN: data_parity_n_in};
      pinS2_q     <= pinS1_q;
      validS_q    <= {validS_q[0], data_valid_n_in};
      busyS_q     <= {busyS_q[0], data_bus_in_use_n_in};
   end

   // ************************************************************
   // Link-side driver state machine
   // ************************************************************
   sbdp_state_t state_q, state_d;
   logic        ackTgl_d;
   logic        wordPending;
   sbdp_bus_t   enc;
   logic [63:0] dOut_q, dOut_d;
   logic [3:0]  invOut_q, invOut_d, parOut_q, parOut_d;
   logic        dOe_q, dOe_d;
   logic        validN_q, validN_d, validOe_q, validOe_d;
   logic        busyN_q, busyN_d, busyOe_q, busyOe_d;

   assign wordPending = (reqSync_q[1] != txAckTgl_q);
   assign enc         = encode(txHold_q.data, dOut_q);

   always_comb
   begin
      state_d   = state_q;
      ackTgl_d  = txAckTgl_q;
      dOut_d    = dOut_q;
      invOut_d  = invOut_q;
      parOut_d  = parOut_q;
      dOe_d     = dOe_q;
      validN_d  = `SBDP_NEG_RST;
      validOe_d = validOe_q;
      busyN_d   = busyN_q;
      busyOe_d  = busyOe_q;
      case (state_q)
         SBDP_IDLE:
         begin
            if (wordPending)
            begin
               state_d = SBDP_WAIT;
            end
         end
         SBDP_WAIT:
         begin
            // Seen through two flops, so the wait is conservative
            if (busyS_q[1] && validS_q[1])
            begin
               state_d   = SBDP_DRIVE;
               busyN_d   = 1'b0;
               busyOe_d  = 1'b1;
               dOe_d     = 1'b1;
               validOe_d = 1'b1;
            end
         end
         SBDP_DRIVE:
         begin
            // Without a fresh word the clock goes out idle, valid high
            if (wordPending)
            begin
               dOut_d   = enc.data;
               invOut_d = enc.invN;
               parOut_d = enc.parN;
               validN_d = 1'b0;
               ackTgl_d = ~txAckTgl_q;
               if (txHold_q.last)
               begin
                  state_d = SBDP_RELEASE;
               end
            end
         end
         SBDP_RELEASE:
         begin
            state_d   = SBDP_IDLE;
            busyN_d   = 1'b1;
            busyOe_d  = 1'b0;
            dOe_d     = 1'b0;
            validOe_d = 1'b0;
         end
         default:
         begin
            state_d = SBDP_IDLE;
         end
      endcase
   end

   always_ff @(posedge busClk)
   begin
      if (lnkRst)
      begin
         state_q    <= SBDP_IDLE;
         txAckTgl_q <= 1'b0;
         dOut_q     <= '0;
         invOut_q   <= 4'hF;
         parOut_q   <= 4'hF;
         dOe_q      <= 1'b0;
         validN_q   <= `SBDP_NEG_RST;
         validOe_q  <= 1'b0;
         busyN_q    <= `SBDP_NEG_RST;
         busyOe_q   <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         txAckTgl_q <= ackTgl_d;
         dOut_q     <= dOut_d;
         invOut_q   <= invOut_d;
         parOut_q   <= parOut_d;
         dOe_q      <= dOe_d;
         validN_q   <= validN_d;
         validOe_q  <= validOe_d;
         busyN_q    <= busyN_d;
         busyOe_q   <= busyOe_d;
      end
   end

   assign dataOut               = dOut_q;
   assign dataOe                = dOe_q;
   assign group_inverted_n_out  = invOut_q;
   assign data_parity_n_out     = parOut_q;
   assign data_valid_n_out      = validN_q;
   assign data_valid_n_oe       = validOe_q;
   assign data_bus_in_use_n_out = busyN_q;
   assign data_bus_in_use_n_oe  = busyOe_q;

   // ************************************************************
   // Link-side receive capture
   // ************************************************************
   // Beats can come faster than the core clock; a beat that finds the
   // previous one untaken is dropped and flagged rather than stalling the bus
   logic [63:0] rxHold_q, rxHold_d;
   logic        rxErr_q, rxErr_d;
   logic        rxTgl_q, rxTgl_d;
   logic        lost_q, lost_d;
   logic [1:0]  ownS_q, ownS_d;
   logic        rxTake;
   logic [63:0] rxPlain;

   // Our own beats come back through the pin flops two clocks late; mask them
   assign rxTake = !validS_q[1] && !ownS_q[1];

   always_comb
   begin
      rxHold_d = rxHold_q;
      rxErr_d  = rxErr_q;
      rxTgl_d  = rxTgl_q;
      lost_d   = lost_q;
      ownS_d   = {ownS_q[0], validOe_q};
      rxPlain  = pinS2_q.data;
      for (int g = 0; g < `SBDP_GRPS; g++)
      begin
         if (!pinS2_q.invN[g])
         begin
            rxPlain[g*16 +: 16] = ~pinS2_q.data[g*16 +: 16];
         end
      end
      if (rxTake)
      begin
         if (rxTgl_q != rxAckSync_q[1])
         begin
            lost_d = 1'b1;
         end
         else
         begin
            rxHold_d = rxPlain;
            rxErr_d  = (busParityN(pinS2_q.data) != pinS2_q.parN);
            rxTgl_d  = ~rxTgl_q;
         end
      end
   end

   always_ff @(posedge busClk)
   begin
      if (lnkRst)
      begin
         rxHold_q <= '0;
         rxErr_q  <= 1'b0;
         rxTgl_q  <= 1'b0;
         lost_q   <= 1'b0;
         ownS_q   <= 2'h0;
      end
      else
      begin
         rxHold_q <= rxHold_d;
         rxErr_q  <= rxErr_d;
         rxTgl_q  <= rxTgl_d;
         lost_q   <= lost_d;
         ownS_q   <= ownS_d;
      end
   end

   // ************************************************************
   // Core-side receive delivery and completion_postponed_n indication
   // ************************************************************
   logic [1:0]  rxTglSync_q, lostSync_q, deferSync_q;
   logic        rxSeen_q, rxSeen_d;
   logic [63:0] rxWord_q, rxWord_d;
   logic        rxValid_q, rxValid_d, rxPErr_q, rxPErr_d;
   logic        rxOvr_q, deferSeen_q;

   always_ff @(posedge busClk)
   begin
      rxAckSync_q <= {rxAckSync_q[0], rxSeen_q};
   end

   always_comb
   begin
      rxSeen_d  = rxSeen_q;
      rxWord_d  = rxWord_q;
      rxPErr_d  = rxPErr_q;
      rxValid_d = 1'b0;
      if (rxTglSync_q[1] != rxSeen_q)
      begin
         rxSeen_d  = rxTglSync_q[1];
         rxWord_d  = rxHold_q;
         rxPErr_d  = rxErr_q;
         rxValid_d = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      rxTglSync_q <= {rxTglSync_q[0], rxTgl_q};
      lostSync_q  <= {lostSync_q[0], lost_q};
      deferSync_q <= {deferSync_q[0], completion_postponed_n};
      if (sys_rst)
      begin
         rxSeen_q    <= 1'b0;
         rxWord_q    <= '0;
         rxValid_q   <= 1'b0;
         rxPErr_q    <= 1'b0;
         rxOvr_q     <= 1'b0;
         deferSeen_q <= 1'b0;
      end
      else
      begin
         rxSeen_q    <= rxSeen_d;
         rxWord_q    <= rxWord_d;
         rxValid_q   <= rxValid_d;
         rxPErr_q    <= rxPErr_d;
         rxOvr_q     <= lostSync_q[1];
         deferSeen_q <= !deferSync_q[1];
      end
   end

   assign rxWord      = rxWord_q;
   assign rxValid     = rxValid_q;
   assign rxParityErr = rxPErr_q;
   assign rxOverrun   = rxOvr_q;
   assign deferSeen   = deferSeen_q;

endmodule // sbdp_data_phase

// ==== tb/sbdp_properties.sv ====
`timescale 1ns/1ps
module sbdp_properties
   import sbdp_pkg::*;
(
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        busClk,
   input wire logic [63:0] dataOut,
   input wire logic        dataOe,
   input wire logic [3:0]  data_parity_n_out,
   input wire logic        data_valid_n_out,
   input wire logic        data_valid_n_oe,
   input wire logic        data_bus_in_use_n_in,
   input wire logic        data_bus_in_use_n_out,
   input wire logic        data_bus_in_use_n_oe,
   input wire logic        completion_postponed_n,
   input wire logic        deferSeen
);
   //********
   // Checks
   //********
   logic [63:0] lastW_q;
   wire         vLow = data_valid_n_oe && !data_valid_n_out;
   always_ff @(posedge busClk)
      if (sys_rst)
         lastW_q <= '0;
      else if (vLow)
         lastW_q <= dataOut;
   sequence s_allOff;
      !dataOe && !data_valid_n_oe && !data_bus_in_use_n_oe;
   endsequence
   property p_busyBeat;
      @(posedge busClk) disable iff (sys_rst)
      vLow |-> !data_bus_in_use_n_out && data_bus_in_use_n_oe;
   endproperty
   a_busyBeat: assert property (p_busyBeat) else $error("beat without busy");
   property p_lead;
      @(posedge busClk) disable iff (sys_rst)
      $fell(data_bus_in_use_n_out) |-> data_valid_n_out && dataOe;
   endproperty
   a_lead: assert property (p_lead) else $error("busy not ahead of beat");
   property p_release;
      @(posedge busClk) disable iff (sys_rst)
      $rose(data_bus_in_use_n_out) |-> s_allOff;
   endproperty
   a_release: assert property (p_release) else $error("pins kept after busy");
   property p_start;
      @(posedge busClk) disable iff (sys_rst)
      $rose(data_bus_in_use_n_oe) |-> $past(data_bus_in_use_n_in)
         && $past(data_bus_in_use_n_in, 2);
   endproperty
   a_start: assert property (p_start) else $error("took a busy bus");
   property p_validOe;
      @(posedge busClk) disable iff (sys_rst) vLow |-> dataOe;
   endproperty
   a_validOe: assert property (p_validOe) else $error("valid without data");
   property p_parity;
      @(posedge busClk) disable iff (sys_rst) vLow |-> data_parity_n_out ==
         {~^dataOut[63:48], ~^dataOut[47:32], ~^dataOut[31:16], ~^dataOut[15:0]};
   endproperty
   a_parity: assert property (p_parity) else $error("bad parity");
   property p_dbi;
      @(posedge busClk) disable iff (sys_rst) vLow |->
         $countones(dataOut[15:0] ^ lastW_q[15:0]) <= 8
         && $countones(dataOut[31:16] ^ lastW_q[31:16]) <= 8
         && $countones(dataOut[47:32] ^ lastW_q[47:32]) <= 8
         && $countones(dataOut[63:48] ^ lastW_q[63:48]) <= 8;
   endproperty
   a_dbi: assert property (p_dbi) else $error("group toggled too much");
   property p_completion_postponed_n;
      @(posedge mclk) disable iff (sys_rst) !completion_postponed_n [*4] |-> deferSeen;
   endproperty
   a_completion_postponed_n: assert property (p_completion_postponed_n) else $error("completion_postponed_n missed");
endmodule // sbdp_properties
bind sbdp_data_phase sbdp_properties u_props (.mclk, .sys_rst, .busClk, .dataOut, .dataOe,
   .data_parity_n_out, .data_valid_n_out, .data_valid_n_oe, .data_bus_in_use_n_in,
   .data_bus_in_use_n_out, .data_bus_in_use_n_oe, .completion_postponed_n, .deferSeen);

// ==== tb/sbdp_agent.sv ====
`timescale 1ns/1ps
module sbdp_agent
   import sbdp_pkg::*;
(
   input wire logic    busClk,
   input wire logic    bsyNW,
   output logic [63:0] pD,
   output logic [3:0]  pInvN,
   output logic [3:0]  pParN,
   output logic        pVldN,
   output logic        pBsyN
);
   //********
   // Far agent
   //********
   logic [63:0] last = '0;
   initial {pD, pInvN, pParN, pVldN, pBsyN} = {64'hA5A5_A5A5_A5A5_A5A5, 10'h3FF};
   task automatic hold(input int n);
      @(posedge busClk);
      pBsyN <= 1'b0;
      repeat (n) @(posedge busClk);
      pBsyN <= 1'b1;
   endtask
   task automatic send(input logic [63:0] w, input logic bad);
      logic [63:0] x;
      logic [3:0]  inv;
      x = w;
      inv = 4'h0;
      @(posedge busClk);
      while (bsyNW !== 1'b1) @(posedge busClk);
      for (int g = 0; g < 4; g++)
         if ($countones(w[g*16+:16] ^ last[g*16+:16]) > 8)
         begin
            inv[g] = 1'b1;
            x[g*16+:16] = ~w[g*16+:16];
         end
      last = x;
      pBsyN <= 1'b0;
      @(posedge busClk);
      pD <= x;
      pInvN <= ~inv;
      pParN <= {~^x[63:48], ~^x[47:32], ~^x[31:16], ~^x[15:0]} ^ {3'h0, bad};
      pVldN <= 1'b0;
      @(posedge busClk);
      pVldN <= 1'b1;
      pD <= ~x;
      repeat (8) @(posedge busClk);
      pBsyN <= 1'b1;
   endtask
endmodule // sbdp_agent

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
   import sbdp_pkg::*;
();
   //********
   // Bench
   //********
   logic        mclk = 1'b0;
   logic        busClk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [63:0] txWord = '0;
   logic        txLast = 1'b0;
   logic        txValid = 1'b0;
   logic        completion_postponed_n = 1'b1;
   logic        txReady, rxValid, rxParityErr, rxOverrun, deferSeen, dataOe;
   logic        vldNOut, vldNOe, bsyNOut, bsyNOe, pVldN, pBsyN, vldNW, bsyNW;
   logic [63:0] rxWord, dataOut, pD, dW;
   logic [3:0]  invNOut, parNOut, pInvN, pParN, invNW, parNW;
   int          err_total = 0;
   int          n_compared = 0;
   int          cyc = 0;
   logic [71:0] txQ[$];
   logic [64:0] rxQ[$];
   initial forever #50 mclk = ~mclk;
   initial
   begin
      #17;
      forever #32 busClk = ~busClk;
   end
   // Whoever has output enable owns the wire; valid and busy are wired-low
   assign dW    = dataOe ? dataOut : pD;
   assign invNW = dataOe ? invNOut : pInvN;
   assign parNW = dataOe ? parNOut : pParN;
   assign vldNW = (vldNOe ? vldNOut : 1'b1) & pVldN;
   assign bsyNW = (bsyNOe ? bsyNOut : 1'b1) & pBsyN;
   sbdp_data_phase dut (.mclk, .sys_rst, .busClk, .txWord, .txLast, .txValid, .txReady,
      .rxWord, .rxValid, .rxParityErr, .rxOverrun, .deferSeen, .dataIn(dW), .dataOut,
      .dataOe, .group_inverted_n_in(invNW), .group_inverted_n_out(invNOut),
      .data_parity_n_in(parNW), .data_parity_n_out(parNOut), .data_valid_n_in(vldNW),
      .data_valid_n_out(vldNOut), .data_valid_n_oe(vldNOe), .data_bus_in_use_n_in(bsyNW),
      .data_bus_in_use_n_out(bsyNOut), .data_bus_in_use_n_oe(bsyNOe),
      .completion_postponed_n);
   sbdp_agent agent (.busClk, .bsyNW, .pD, .pInvN, .pParN, .pVldN, .pBsyN);
   // Mid-beat sampling keeps the monitors clear of the launching edges
   always @(negedge busClk)
      if (dataOe === 1'b1 && vldNW === 1'b0)
         txQ.push_back({dW, invNW, parNW});
   always @(negedge mclk)
   begin
      if (rxValid === 1'b1)
         rxQ.push_back({rxParityErr, rxWord});
      if (++cyc == 3000)
      begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic summarize;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic put(input logic [63:0] w, input logic l);
      @(negedge mclk);
      while (txReady !== 1'b1) @(negedge mclk);
      txWord = w;
      txLast = l;
      txValid = 1'b1;
      @(negedge mclk);
      txValid = 1'b0;
   endtask
   task automatic t_tx;
      logic [63:0] w [3];
      logic [3:0]  inv [3];
      logic [71:0] b;
      logic [63:0] d;
      w = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h00FF_00FF_00FF_00FF};
      inv = '{4'hF, 4'h0, 4'hF};
      fork
         agent.hold(40);
      join_none
      repeat (3) @(negedge mclk);
      put(w[0], 1'b0);
      repeat (10) @(negedge mclk);
      chk(64'(dataOe), 64'h0, "drove a busy bus");
      put(w[1], 1'b0);
      put(w[2], 1'b1);
      repeat (30) @(negedge mclk);
      chk(64'(txQ.size()), 64'h3, "beat count");
      for (int k = 0; k < 3; k++)
      begin
         b = txQ.pop_front();
         d = b[71:8];
         for (int g = 0; g < 4; g++)
            if (b[4+g] == 1'b0)
               d[g*16+:16] = ~d[g*16+:16];
         chk(d, w[k], "tx word");
         chk(64'(b[7:4]), 64'(inv[k]), "tx inversion");
         chk(64'(b[3:0]), 64'({~^b[71:56], ~^b[55:40], ~^b[39:24], ~^b[23:8]}),
            "tx parity");
      end
      $display("t_tx done");
   endtask
   task automatic t_rx(input logic [63:0] w, input logic bad);
      logic [64:0] r;
      agent.send(w, bad);
      repeat (8) @(negedge mclk);
      chk(64'(rxQ.size()), 64'h1, "rx count");
      r = rxQ.pop_front();
      chk(r[63:0], w, "rx word");
      chk(64'(r[64]), 64'(bad), "rx parity flag");
      chk(64'(rxOverrun), 64'h0, "no beat dropped");
      $display("t_rx done");
   endtask
   task automatic t_completion_postponed_n;
      @(negedge mclk);
      completion_postponed_n = 1'b0;
      repeat (4) @(negedge mclk);
      chk(64'(deferSeen), 64'h1, "completion_postponed_n seen");
      completion_postponed_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk(64'(deferSeen), 64'h0, "completion_postponed_n cleared");
      $display("t_completion_postponed_n done");
   endtask
   initial
   begin
      repeat (10) @(negedge mclk);
      sys_rst = 1'b0;
      t_completion_postponed_n();
      t_tx();
      t_rx(64'h1234_5678_9ABC_DEF0, 1'b0);
      t_rx(64'hFFFF_FFFF_0000_00FF, 1'b1);
      summarize();
   end
endmodule // testbench
